// ==== dv/clock_network_control_block_tb.sv ====
// self-checking bench for the clock network control block
`timescale 1ns/1ps
`default_nettype none
module clock_network_control_block_tb;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0000_0000;
	logic [31:0] prd;
	logic prdy, perr;
	logic [15:0] gdsel = 16'h0000, gen = 16'h0000, ren = 16'h0000;
	logic [1:0] pden = 2'h0, pint = 2'h0;
	logic [15:0] pins, gout, rout;
	logic [3:0] p0, p1, ir;
	logic [2:0] logic_array_block;
	logic [7:0] io;
	logic [1:0] ppo;
	logic [44:0] allv;
	logic [7:0] tcnt = 8'h00;
	logic [32:0] expq[$];
	logic [32:0] e;
	int mismatches = 0;
	int checks = 0;
	int seed = 32'hdab33b98;
	assign allv = {ppo, io, logic_array_block, rout, gout};
	initial forever #2.5 clk_in = ~clk_in;
	// user-side signals for the dual-purpose pins, half period 8 on pin 0 and 16 on pin 1
	always @(posedge clk_in) begin
		tcnt <= tcnt + 8'h01;
		pint <= {tcnt[4], tcnt[3]};
	end
	cnc_partner part_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .pin_out(pins),
		.pll0_out(p0), .pll1_out(p1), .int_out(ir));
	cnc_top dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
		.pslverr_out(perr), .dedicated_clock_input_pin_in(pins), .pll_output_zero_in(p0),
		.pll_output_one_in(p1), .int_route_in(ir), .glb_dyn_sel_in(gdsel), .glb_dyn_en_in(gen),
		.reg_dyn_en_in(ren), .pin_dyn_en_in(pden), .pin_int_in(pint),
		.global_clock_net_out(gout), .regional_clock_out(rout),
		.logic_array_block_clk_out(logic_array_block), .io_element_clk_out(io), .pll_pin_out(ppo));
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one apb transfer; an idle edge follows so psel is never assigned twice in a step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk_in);
		pen <= 1'b1;
		do begin
			@(posedge clk_in);
			k++;
		end while (prdy !== 1'b1 && k < 20);
		if (k >= 20) begin
			mismatches++;
			tally_and_finish();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_in);
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] d, input logic err);
		expq.push_back({err, d});
		apb(1'b0, a, 32'h0000_0000);
	endtask
	// wait for the gate to settle, then count rising edges over 128 cycles
	task rises(input int idx, input int exp);
		int n;
		logic pv;
		repeat (40) @(negedge clk_in);
		pv = allv[idx];
		n = 0;
		repeat (128) begin
			@(negedge clk_in);
			if (allv[idx] === 1'b1 && pv !== 1'b1) n++;
			pv = allv[idx];
		end
		chk("rises", 32'(exp), 32'(n));
		@(posedge clk_in);
	endtask
	// read results are checked against the oldest note when the access completes
	always @(posedge clk_in) begin
		if (psel && pen && prdy === 1'b1 && !pwr) begin
			if (expq.size() == 0) chk("queue", 32'h0, 32'h1);
			else begin
				e = expq.pop_front();
				chk("prdata", e[31:0], prd);
				chk("pslverr", {31'h0, e[32]}, {31'h0, perr});
			end
		end
	end
	initial begin
		repeat (100000) @(posedge clk_in);
		mismatches++;
		tally_and_finish();
	end
	initial begin
		int s;
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		@(posedge clk_in);
		rd(12'h100, cnc_pkg::RST_GLB, 1'b0);
		rd(12'h200, cnc_pkg::RST_REG, 1'b0);
		rd(12'h320, cnc_pkg::RST_BLK, 1'b0);
		rd(12'hFFC, 32'h0000_0000, 1'b1);
		wr(12'h000, 32'hFFFF_FFFF);
		rd(12'h000, 32'h0000_0000, 1'b0);
		gen <= 16'h0001;
		// static select: last index, then random ones
		for (int i = 0; i < 5; i++) begin
			s = (i == 0) ? 27 : {$random(seed)} % 28;
			wr(12'h100, 32'(s));
			rises(0, 16 >> (s % 4));
		end
		rd(12'h000, 32'h0000_0001, 1'b0);
		gen <= 16'h0000;
		rises(0, 0);
		rd(12'h000, 32'h0000_0000, 1'b0);
		gen <= 16'h0001;
		wr(12'h100, 32'h0100_0000);
		rises(0, 0);
		// dynamic mode on global 0, which the candidate-path check watches: cand0 pin 0, cand1 pll 0 output one
		wr(12'h100, 32'h0011_0020);
		for (int k = 0; k < 2; k++) begin
			gdsel[0] <= k[0];
			rises(0, k ? 8 : 16);
		end
		ren <= 16'hFFFF;
		wr(12'h200, 32'h0000_0000);
		rises(16, 0);
		wr(12'h200, 32'h0000_0004);
		rises(16, 16);
		// every other regional line still selects a left-side pin and is flagged
		rd(12'h008, 32'h0000_FFFE, 1'b0);
		// only regional line 0 has its static off bit cleared
		rd(12'h004, 32'h0000_0001, 1'b0);
		// dual line 8 follows line 0 under the direction rules
		wr(12'h00C, 32'h0000_0001);
		rd(12'h00C, 32'h0000_0001, 1'b0);
		wr(12'h220, 32'h0000_0020);
		wr(12'h200, 32'h0000_0010);
		rises(24, 16);
		wr(12'h200, 32'h0000_0012);
		rises(24, 0);
		wr(12'h200, 32'h0000_0014);
		rises(24, 0);
		wr(12'h00C, 32'h0000_0000);
		rises(24, 16);
		// row, block and io buses from global 0 on pin 0; row 2, and so block 2, from powered-down regional line 1
		wr(12'h100, 32'h0000_0000);
		wr(12'h308, 32'h0000_0011);
		rises(32, 16);
		rises(34, 0);
		rises(35, 16);
		pden <= 2'h1;
		wr(12'h380, 32'h0000_0000);
		rises(43, 8);
		wr(12'h380, 32'h0000_0010);
		rises(43, 16);
		pden <= 2'h0;
		rises(43, 0);
		tally_and_finish();
	end
endmodule // clock_network_control_block_tb
`default_nettype wire

// ==== dv/cnc_partner.sv ====
// free-running clock sources standing in for pins, plls and routing
`timescale 1ns/1ps
`default_nettype none
module cnc_partner (
	input wire logic clk_in,
	input wire logic reset_n_in,
	output logic [15:0] pin_out,
	output logic [3:0] pll0_out,
	output logic [3:0] pll1_out,
	output logic [3:0] int_out
);
	logic [7:0] cnt_q;
	// one shared counter keeps every source phase-locked, so rise counts are exact
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) cnt_q <= 8'h00;
		else cnt_q <= cnt_q + 8'h01;
	end
	// source s has half period 4 << (s % 4): a wrong select shows as a rate change
	always_comb begin
		for (int i = 0; i < 16; i++) pin_out[i] = cnt_q[2 + i % 4];
		for (int p = 0; p < 4; p++) begin
			pll0_out[p] = cnt_q[2 + (2 * p) % 4];
			pll1_out[p] = cnt_q[3 + (2 * p) % 4];
			int_out[p] = cnt_q[2 + p];
		end
	end
endmodule // cnc_partner
`default_nettype wire

// ==== src/cnc_gate.sv ====
// synchronous power-down gate for one clock line
`timescale 1ns/1ps
`default_nettype none
module cnc_gate (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic src_in,
	input wire logic enable_in,
	output logic gated_out,
	output logic on_out
);
	logic en_q;
	logic gated_q;
	// enable moves only while the source rests low, so no pulse is cut short
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			en_q <= 1'b0;
		end else if (!src_in) begin
			en_q <= enable_in;
		end
	end
	// gate acts after source selection; a dead line rests low
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			gated_q <= 1'b0;
		end else begin
			gated_q <= src_in & en_q;
		end
	end
	assign gated_out = gated_q;
	assign on_out = en_q;
	a_gate_enable_stable: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$past(src_in) |-> $stable(en_q)) else $error("gate enable moved while source high");
	a_gate_held_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(!en_q) [*2] |-> !gated_out) else $error("powered-down line not held low");
	a_gate_follows_src: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(en_q && src_in) |=> gated_out) else $error("enabled line failed to pass source high");
endmodule // cnc_gate
`default_nettype wire

// ==== src/cnc_pkg.sv ====
// constants, types and register map of the clock network control block
package cnc_pkg;
	// source vector: 16 clock pins, 8 pll outputs, 4 internal routing lines
	localparam int NUM_PIN = 16;
	localparam int NUM_PLLS = 4;
	localparam int NUM_PLL_OUT = 8;
	localparam int NUM_INT = 4;
	localparam int NUM_SYNC = 24;
	localparam int NUM_SRC = 28;
	localparam int SEL_W = 5;
	localparam int NUM_GLOBAL = 16;
	localparam int NUM_REG_Q = 8;
	localparam int NUM_REGION = 16;
	localparam int NUM_RES = 24;
	localparam int NUM_ROW = 6;
	localparam int NUM_BLK = 3;
	localparam int NUM_IO = 8;
	localparam int NUM_PLLPIN = 2;
	localparam int NUM_LINE = 34;
	localparam int LINE_REG_BASE = 16;
	localparam int LINE_PIN_BASE = 32;
	localparam logic [4:0] SRC_LAST = 5'h1B;
	localparam logic [4:0] PIN_LAST = 5'h0F;
	localparam logic [4:0] PLL_LAST = 5'h17;
	localparam logic [4:0] RES_LAST = 5'h17;
	localparam logic [2:0] ROW_LAST = 3'h5;
	// pin sides and pll classes
	localparam logic [15:0] TB_PIN_MASK = 16'hF0F0;
	localparam logic [15:0] LR_PIN_MASK = 16'h0F0F;
	localparam logic [7:0] FAST_PLL_MASK = 8'h0F;
	localparam logic [7:0] CORNER_PLL_MASK = 8'h0C;
	localparam logic [7:0] ENH_PLL_MASK = 8'hF0;
	// register byte addresses
	localparam logic [11:0] ADDR_STAT_BASE = 12'h000;
	localparam logic [11:0] ADDR_GLB_BASE = 12'h100;
	localparam logic [11:0] ADDR_REG_BASE = 12'h200;
	localparam logic [11:0] ADDR_ROW_BASE = 12'h300;
	localparam logic [11:0] ADDR_BLK = 12'h320;
	localparam logic [11:0] ADDR_IO_BASE = 12'h340;
	localparam logic [11:0] ADDR_PIN_BASE = 12'h380;
	localparam logic [1:0] STAT_GLB_ON = 2'h0;
	localparam logic [1:0] STAT_REG_ON = 2'h1;
	localparam logic [1:0] STAT_REG_ERR = 2'h2;
	localparam logic [1:0] STAT_DUAL_DIR = 2'h3;
	// field positions
	localparam int F_SEL_LSB = 0;
	localparam int F_DYN_BIT = 5;
	localparam int F_CAND0_LSB = 8;
	localparam int F_CAND1_LSB = 16;
	localparam int F_OFF_BIT = 24;
	localparam int F_DUAL_BIT = 5;
	localparam int F_USECLK_BIT = 4;
	localparam int F_BLK_STEP = 4;
	localparam int F_VERT_BIT = 0;
	// reset values: nets start powered down, as unused nets are
	localparam logic [31:0] RST_GLB = 32'h0100_0000;
	localparam logic [31:0] RST_REG = 32'h0100_0000;
	localparam logic [31:0] RST_ROW = 32'h0000_0000;
	localparam logic [31:0] RST_BLK = 32'h0000_0210;
	localparam logic [31:0] RST_IO = 32'h0000_0000;
	localparam logic [31:0] RST_PIN = 32'h0000_0000;
	localparam logic [31:0] RST_DIR = 32'h0000_0000;
	// decoded register kind, one-hot
	typedef enum logic [7:0] {
		KIND_NONE = 8'h01,
		KIND_STAT = 8'h02,
		KIND_GLB = 8'h04,
		KIND_REG = 8'h08,
		KIND_ROW = 8'h10,
		KIND_BLK = 8'h20,
		KIND_IO = 8'h40,
		KIND_PIN = 8'h80
	} cnc_kind_type;
	typedef struct packed {
		cnc_kind_type kind;
		logic [4:0] idx;
	} cnc_dec_type;
endpackage

// ==== src/cnc_sync.sv ====
// two-flop synchroniser for clock levels arriving from outside the domain
`timescale 1ns/1ps
`default_nettype none
module cnc_sync #(
	parameter int WIDTH = 24
) (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);
	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;
	// first stage is read only by the second stage
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_in;
			sync_q <= meta_q;
		end
	end
	assign q_out = sync_q;
endmodule // cnc_sync
`default_nettype wire

// ==== src/cnc_top.sv ====
// clock network control: source selection and power-down for every clock line
//
// Summary of operation
// - every line gets its own select-and-gate unit
// - quadrant has 24 resources: 16 global, 8 regional
// - block mux picks three of six row clocks
// - io region takes eight of 24 resources
// - global select from configuration or user logic
// - static select may choose any source input
// - dynamic global select toggles between two candidates
// - regional and pin selects set by configuration only
// - regional pins limited to top and bottom
// - user enable gates line synchronously to clock
// - gating follows selection, independent of plls
// - powered-down line holds its logic inactive
// - configuration statically disables unused global, regional nets
// - pll pin passes internal signal or clock
// - one source drives regional lines in two quadrants
// - dual direction decides which pins and plls qualify
// - corner plls never feed dual-regional clocks
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module cnc_top (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [15:0] dedicated_clock_input_pin_in,
	input wire logic [3:0] pll_output_zero_in,
	input wire logic [3:0] pll_output_one_in,
	input wire logic [3:0] int_route_in,
	input wire logic [15:0] glb_dyn_sel_in,
	input wire logic [15:0] glb_dyn_en_in,
	input wire logic [15:0] reg_dyn_en_in,
	input wire logic [1:0] pin_dyn_en_in,
	input wire logic [1:0] pin_int_in,
	output logic [15:0] global_clock_net_out,
	output logic [15:0] regional_clock_out,
	output logic [2:0] logic_array_block_clk_out,
	output logic [7:0] io_element_clk_out,
	output logic [1:0] pll_pin_out
);
	// configuration store
	logic [31:0] glb_q [cnc_pkg::NUM_GLOBAL];
	logic [31:0] reg_q [cnc_pkg::NUM_REGION];
	logic [31:0] row_q [cnc_pkg::NUM_ROW];
	logic [31:0] io_q [cnc_pkg::NUM_IO];
	logic [31:0] pin_q [cnc_pkg::NUM_PLLPIN];
	logic [31:0] blk_q;
	logic [31:0] dir_q;
	logic [31:0] prdata_q;
	logic [31:0] rdata_d;
	logic pslverr_q;
	logic wr_en;
	logic setup_ph;
	cnc_pkg::cnc_dec_type dec;
	// source levels and per-line signals
	logic [7:0] pll_raw;
	logic [23:0] sync_lvl;
	logic [cnc_pkg::NUM_SRC-1:0] src_lvl;
	logic [cnc_pkg::NUM_LINE-1:0] line_lvl;
	logic [cnc_pkg::NUM_LINE-1:0] line_en;
	logic [cnc_pkg::NUM_LINE-1:0] gated;
	logic [cnc_pkg::NUM_LINE-1:0] line_on;
	logic [15:0] reg_bad;
	logic [cnc_pkg::NUM_RES-1:0] res_lvl;
	logic [cnc_pkg::NUM_ROW-1:0] row_clk_q;
	logic [cnc_pkg::NUM_BLK-1:0] blk_clk_q;
	logic [cnc_pkg::NUM_IO-1:0] io_clk_q;
	logic [1:0] pll_pin_q;
	logic cand1_lvl0;
	logic blk0_lvl;

	// address decode, shared by the write path and the read path
	function automatic cnc_pkg::cnc_dec_type decode(input logic [11:0] addr);
		cnc_pkg::cnc_dec_type d;
		d.kind = cnc_pkg::KIND_NONE;
		d.idx = {3'h0, addr[3:2]};
		if (addr[1:0] != 2'h0) begin
			d.kind = cnc_pkg::KIND_NONE;
		end else if (addr[11:4] == cnc_pkg::ADDR_STAT_BASE[11:4]) begin
			d.kind = cnc_pkg::KIND_STAT;
		end else if (addr[11:6] == cnc_pkg::ADDR_GLB_BASE[11:6]) begin
			d.kind = cnc_pkg::KIND_GLB;
			d.idx = {1'b0, addr[5:2]};
		end else if (addr[11:6] == cnc_pkg::ADDR_REG_BASE[11:6]) begin
			d.kind = cnc_pkg::KIND_REG;
			d.idx = {1'b0, addr[5:2]};
		end else if (addr[11:5] == cnc_pkg::ADDR_ROW_BASE[11:5] && addr[4:2] <= cnc_pkg::ROW_LAST) begin
			d.kind = cnc_pkg::KIND_ROW;
			d.idx = {2'h0, addr[4:2]};
		end else if (addr == cnc_pkg::ADDR_BLK) begin
			d.kind = cnc_pkg::KIND_BLK;
		end else if (addr[11:5] == cnc_pkg::ADDR_IO_BASE[11:5]) begin
			d.kind = cnc_pkg::KIND_IO;
			d.idx = {2'h0, addr[4:2]};
		end else if (addr[11:3] == cnc_pkg::ADDR_PIN_BASE[11:3]) begin
			d.kind = cnc_pkg::KIND_PIN;
			d.idx = {4'h0, addr[2]};
		end
		return d;
	endfunction

	// out-of-range selects yield a quiet low rather than a random source
	function automatic logic pick(input logic [cnc_pkg::NUM_SRC-1:0] lvl, input logic [4:0] idx);
		logic r;
		r = 1'b0;
		if (idx <= cnc_pkg::SRC_LAST) begin
			r = lvl[idx];
		end
		return r;
	endfunction

	// regional mux accepts top and bottom pins, plls and routing
	function automatic logic reg_ok(input logic [4:0] idx);
		logic r;
		r = 1'b0;
		if (idx <= cnc_pkg::PIN_LAST) begin
			r = cnc_pkg::TB_PIN_MASK[idx[3:0]];
		end else if (idx <= cnc_pkg::SRC_LAST) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// dual-regional sources depend on the direction of the pairing
	function automatic logic dual_ok(input logic [4:0] idx, input logic vert);
		logic r;
		r = 1'b0;
		if (idx <= cnc_pkg::PIN_LAST) begin
			r = vert ? cnc_pkg::LR_PIN_MASK[idx[3:0]] : cnc_pkg::TB_PIN_MASK[idx[3:0]];
		end else if (idx <= cnc_pkg::PLL_LAST) begin
			if (cnc_pkg::CORNER_PLL_MASK[idx[2:0]]) begin
				r = 1'b0;
			end else begin
				r = vert ? cnc_pkg::FAST_PLL_MASK[idx[2:0]] : cnc_pkg::ENH_PLL_MASK[idx[2:0]];
			end
		end else if (idx <= cnc_pkg::SRC_LAST) begin
			r = 1'b1;
		end
		return r;
	endfunction

	// apb handshake: one setup cycle, one access cycle, never any wait
	assign dec = decode(paddr_in);
	assign setup_ph = psel_in & ~penable_in;
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign pready_out = psel_in & penable_in;
	assign prdata_out = prdata_q;
	assign pslverr_out = pslverr_q & psel_in & penable_in;

	// configuration writes; the selects are never touched by user-mode logic
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < cnc_pkg::NUM_GLOBAL; i++) begin
				glb_q[i] <= cnc_pkg::RST_GLB;
			end
			for (int i = 0; i < cnc_pkg::NUM_REGION; i++) begin
				reg_q[i] <= cnc_pkg::RST_REG;
			end
			for (int i = 0; i < cnc_pkg::NUM_ROW; i++) begin
				row_q[i] <= cnc_pkg::RST_ROW;
			end
			for (int i = 0; i < cnc_pkg::NUM_IO; i++) begin
				io_q[i] <= cnc_pkg::RST_IO;
			end
			for (int i = 0; i < cnc_pkg::NUM_PLLPIN; i++) begin
				pin_q[i] <= cnc_pkg::RST_PIN;
			end
			blk_q <= cnc_pkg::RST_BLK;
			dir_q <= cnc_pkg::RST_DIR;
		end else if (wr_en) begin
			if (dec.kind == cnc_pkg::KIND_GLB) begin
				glb_q[dec.idx[3:0]] <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_REG) begin
				reg_q[dec.idx[3:0]] <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_ROW) begin
				row_q[dec.idx[2:0]] <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_BLK) begin
				blk_q <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_IO) begin
				io_q[dec.idx[2:0]] <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_PIN) begin
				pin_q[dec.idx[0]] <= pwdata_in;
			end else if (dec.kind == cnc_pkg::KIND_STAT && dec.idx[1:0] == cnc_pkg::STAT_DUAL_DIR) begin
				dir_q <= pwdata_in;
			end
		end
	end

	// read mux; status words 0 to 2 read their upper 16 bits as zero
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (dec.kind == cnc_pkg::KIND_STAT) begin
			if (dec.idx[1:0] == cnc_pkg::STAT_GLB_ON) begin
				rdata_d = {16'h0000, line_on[15:0]};
			end else if (dec.idx[1:0] == cnc_pkg::STAT_REG_ON) begin
				rdata_d = {16'h0000, line_on[31:16]};
			end else if (dec.idx[1:0] == cnc_pkg::STAT_REG_ERR) begin
				rdata_d = {16'h0000, reg_bad};
			end else begin
				rdata_d = dir_q;
			end
		end else if (dec.kind == cnc_pkg::KIND_GLB) begin
			rdata_d = glb_q[dec.idx[3:0]];
		end else if (dec.kind == cnc_pkg::KIND_REG) begin
			rdata_d = reg_q[dec.idx[3:0]];
		end else if (dec.kind == cnc_pkg::KIND_ROW) begin
			rdata_d = row_q[dec.idx[2:0]];
		end else if (dec.kind == cnc_pkg::KIND_BLK) begin
			rdata_d = blk_q;
		end else if (dec.kind == cnc_pkg::KIND_IO) begin
			rdata_d = io_q[dec.idx[2:0]];
		end else if (dec.kind == cnc_pkg::KIND_PIN) begin
			rdata_d = pin_q[dec.idx[0]];
		end
	end

	// read data and error are taken in the setup cycle and held for the access cycle
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (setup_ph) begin
			prdata_q <= pwrite_in ? 32'h0000_0000 : rdata_d;
			pslverr_q <= (dec.kind == cnc_pkg::KIND_NONE);
		end
	end

	// pins and pll outputs come from other clocks: sample through two flops
	for (genvar p = 0; p < cnc_pkg::NUM_PLLS; p++) begin : g_pll_raw
		assign pll_raw[2*p] = pll_output_zero_in[p];
		assign pll_raw[2*p+1] = pll_output_one_in[p];
	end
	cnc_sync #(
		.WIDTH(cnc_pkg::NUM_SYNC)
	) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.d_in({pll_raw, dedicated_clock_input_pin_in}),
		.q_out(sync_lvl)
	);
	// internal routing shares this clock and needs no synchroniser
	assign src_lvl = {int_route_in, sync_lvl};

	// global lines: static select, or user logic choosing one of two candidates
	for (genvar g = 0; g < cnc_pkg::NUM_GLOBAL; g++) begin : g_glb
		logic [4:0] idx;
		logic dyn;
		assign dyn = glb_q[g][cnc_pkg::F_DYN_BIT];
		assign idx = !dyn ? glb_q[g][cnc_pkg::F_SEL_LSB +: cnc_pkg::SEL_W] :
			glb_dyn_sel_in[g] ? glb_q[g][cnc_pkg::F_CAND1_LSB +: cnc_pkg::SEL_W] :
			glb_q[g][cnc_pkg::F_CAND0_LSB +: cnc_pkg::SEL_W];
		assign line_lvl[g] = pick(src_lvl, idx);
		assign line_en[g] = ~glb_q[g][cnc_pkg::F_OFF_BIT] & glb_dyn_en_in[g];
	end

	// regional lines; the second quadrant may share the first one's source
	for (genvar r = 0; r < cnc_pkg::NUM_REGION; r++) begin : g_reg
		logic dual;
		logic [4:0] idx;
		logic bad;
		assign dual = (r >= cnc_pkg::NUM_REG_Q) && reg_q[r][cnc_pkg::F_DUAL_BIT];
		assign idx = dual ? reg_q[r % cnc_pkg::NUM_REG_Q][cnc_pkg::F_SEL_LSB +: cnc_pkg::SEL_W] :
			reg_q[r][cnc_pkg::F_SEL_LSB +: cnc_pkg::SEL_W];
		assign bad = !reg_ok(idx) ||
			(dual && !dual_ok(idx, dir_q[cnc_pkg::F_VERT_BIT]));
		assign reg_bad[r] = bad;
		assign line_lvl[cnc_pkg::LINE_REG_BASE + r] = bad ? 1'b0 : pick(src_lvl, idx);
		assign line_en[cnc_pkg::LINE_REG_BASE + r] = ~reg_q[r][cnc_pkg::F_OFF_BIT] & reg_dyn_en_in[r];
	end

	// external pll pins take any pll output, fixed by configuration
	for (genvar p = 0; p < cnc_pkg::NUM_PLLPIN; p++) begin : g_pin
		assign line_lvl[cnc_pkg::LINE_PIN_BASE + p] = sync_lvl[cnc_pkg::NUM_PIN + 32'(pin_q[p][2:0])];
		assign line_en[cnc_pkg::LINE_PIN_BASE + p] = pin_dyn_en_in[p];
	end

	// one gate per line, downstream of its select and blind to pll state
	for (genvar l = 0; l < cnc_pkg::NUM_LINE; l++) begin : g_gate
		cnc_gate u_gate (
			.clk_in(clk_in),
			.reset_n_in(reset_n_in),
			.src_in(line_lvl[l]),
			.enable_in(line_en[l]),
			.gated_out(gated[l]),
			.on_out(line_on[l])
		);
	end
	assign global_clock_net_out = gated[15:0];
	assign regional_clock_out = gated[31:16];

	// quadrant resources of the first quadrant: 16 global plus 8 regional
	assign res_lvl = {gated[23:16], gated[15:0]};

	// row clocks drawn from the quadrant resources
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			row_clk_q <= '0;
		end else begin
			for (int k = 0; k < cnc_pkg::NUM_ROW; k++) begin
				row_clk_q[k] <= (row_q[k][4:0] <= cnc_pkg::RES_LAST) ? res_lvl[row_q[k][4:0]] : 1'b0;
			end
		end
	end

	// block-level mux: three of the six row clocks
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			blk_clk_q <= '0;
		end else begin
			for (int m = 0; m < cnc_pkg::NUM_BLK; m++) begin
				blk_clk_q[m] <= (blk_q[m*cnc_pkg::F_BLK_STEP +: 3] <= cnc_pkg::ROW_LAST) ?
					row_clk_q[blk_q[m*cnc_pkg::F_BLK_STEP +: 3]] : 1'b0;
			end
		end
	end
	assign logic_array_block_clk_out = blk_clk_q;

	// io region clocks: eight picks from the 24 resources
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			io_clk_q <= '0;
		end else begin
			for (int k = 0; k < cnc_pkg::NUM_IO; k++) begin
				io_clk_q[k] <= (io_q[k][4:0] <= cnc_pkg::RES_LAST) ? res_lvl[io_q[k][4:0]] : 1'b0;
			end
		end
	end
	assign io_element_clk_out = io_clk_q;

	// dual-purpose pll pin: user signal or gated clock
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			pll_pin_q <= '0;
		end else begin
			for (int p = 0; p < cnc_pkg::NUM_PLLPIN; p++) begin
				pll_pin_q[p] <= pin_q[p][cnc_pkg::F_USECLK_BIT] ?
					gated[cnc_pkg::LINE_PIN_BASE + p] : pin_int_in[p];
			end
		end
	end
	assign pll_pin_out = pll_pin_q;

	// helper levels watched by the checks below
	assign cand1_lvl0 = pick(src_lvl, glb_q[0][cnc_pkg::F_CAND1_LSB +: cnc_pkg::SEL_W]);
	assign blk0_lvl = (blk_q[2:0] <= cnc_pkg::ROW_LAST) ? row_clk_q[blk_q[2:0]] : 1'b0;

	a_dyn_select_path: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(glb_q[0][cnc_pkg::F_DYN_BIT] && glb_dyn_sel_in[0] && line_on[0])
		|=> (global_clock_net_out[0] == $past(cand1_lvl0)))
		else $error("dynamic select did not route candidate one");
	a_reg_pin_side: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		reg_bad[0] |=> !regional_clock_out[0])
		else $error("illegal regional source reached the line");
	a_dual_share: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_q[8][cnc_pkg::F_DUAL_BIT] && !reg_bad[8] && !reg_bad[0])
		|-> (line_lvl[24] == line_lvl[16]))
		else $error("dual regional lines do not share one source");
	a_corner_block: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		(reg_q[8][cnc_pkg::F_DUAL_BIT] && reg_q[0][4:3] == 2'b10
		&& cnc_pkg::CORNER_PLL_MASK[reg_q[0][2:0]]) |-> reg_bad[8])
		else $error("corner pll accepted as dual regional source");
	a_pin_mux_user: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!pin_q[0][cnc_pkg::F_USECLK_BIT] |=> (pll_pin_out[0] == $past(pin_int_in[0])))
		else $error("pll pin did not pass the internal signal");
	a_block_pick: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		$stable(blk_q) |=> (logic_array_block_clk_out[0] == $past(blk0_lvl)))
		else $error("block clock not taken from selected row clock");
endmodule // cnc_top
`default_nettype wire
